/* design/ecd_nvm_ctrl.sv */
// Top of the EEPROM paging and timing clock divider slice, with APB
// register file and a pulse-counting program/erase sequencer.
// Assumes nonvolatile image inputs are stable across reset release and
// live in the bus clock domain.
`timescale 1ns/1ps
module ecd_nvm_ctrl #(
  parameter int unsigned EE_AW        = 10,
  parameter int unsigned PULSE_W      = 16,
  parameter int unsigned PROG_PULSES  = 9,
  parameter int unsigned ERASE_PULSES = 4000
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rstn,
  // Register bus
  input  wire ecd_pkg::ecd_apb_req_s     apb_req,
  output      ecd_pkg::ecd_apb_rsp_s     apb_rsp,
  // Nonvolatile image read at reset
  input  wire ecd_pkg::ecd_nv_image_s    nv_image,
  // EEPROM read access
  input  wire logic [EE_AW-1:0]          ee_addr,
  output      logic [EE_AW:0]            ee_phys_addr,
  // Program and erase operation
  output      logic                      op_program,
  output      logic                      op_erase,
  output      logic [EE_AW:0]            op_phys_addr,
  output      logic [EE_AW:0]            op_erase_base,
  output      logic                      timing_pulse,
  // Loaded settings
  output      logic                      divisor_loaded_flag,
  output      logic                      eeprom_page_select,
  output      logic                      eeprom_sector_mode,
  output      logic [ecd_pkg::KEY_W-1:0] comparison_key
);

  generate
    if (PROG_PULSES < 1 || PROG_PULSES >= (1 << PULSE_W) ||
        ERASE_PULSES < 1 || ERASE_PULSES >= (1 << PULSE_W)) begin : g_chk
      $error("ecd_nvm_ctrl: pulse counts do not fit PULSE_W");
    end
    if (EE_AW < ecd_pkg::SECTOR_AW || EE_AW > 16) begin : g_chk_aw
      $error("ecd_nvm_ctrl: EE_AW out of range");
    end
  endgenerate

  localparam logic [PULSE_W-1:0] PROG_CNT  = PULSE_W'(PROG_PULSES);
  localparam logic [PULSE_W-1:0] ERASE_CNT = PULSE_W'(ERASE_PULSES);

  typedef struct packed {
    logic                      loading;
    logic [7:0]                clkdiv;
    logic [7:0]                options;
    logic [7:0]                config_r;
    logic [7:0]                protect;
    logic [EE_AW-1:0]          eeaddr;
    logic [ecd_pkg::KEY_W-1:0] key;
    ecd_pkg::ecd_op_e          op;
    logic                      erasing;
    logic [PULSE_W-1:0]        pulses;
    logic                      done;
    logic                      blocked;
    logic [EE_AW:0]            op_addr;
    logic [EE_AW:0]            op_base;
    logic [EE_AW:0]            rd_addr;
    logic                      pslverr;
    logic [31:0]               prdata;
  } ecd_top_state_s;

  ecd_top_state_s st_ff;
  ecd_top_state_s nxt_st;

  logic           tick;
  logic [EE_AW:0] rd_phys;
  logic [EE_AW:0] cmd_phys;
  logic [EE_AW:0] cmd_base;
  logic           page_sel;
  logic           sect_mode;
  logic           loaded;
  logic           wr_en;
  logic           rd_cap;
  logic [7:0]     wbyte;

  assign page_sel  = st_ff.config_r[ecd_pkg::CFG_PAGE_SEL_BIT];
  assign sect_mode = st_ff.options[ecd_pkg::OPT_SECTOR_MODE_BIT];
  assign loaded    = st_ff.clkdiv[ecd_pkg::DIV_LOADED_BIT];
  assign wr_en     = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign rd_cap    = apb_req.psel & ~apb_req.penable;
  assign wbyte     = apb_req.pwdata[7:0];

  ecd_ee_map #(
    .AW          (EE_AW)
  ) u_map_rd (
    .addr        (ee_addr),
    .page_sel    (page_sel),
    .sector_mode (sect_mode),
    .phys_addr   (rd_phys),
    .erase_base  ()
  );

  ecd_ee_map #(
    .AW          (EE_AW)
  ) u_map_cmd (
    .addr        (st_ff.eeaddr),
    .page_sel    (page_sel),
    .sector_mode (sect_mode),
    .phys_addr   (cmd_phys),
    .erase_base  (cmd_base)
  );

  ecd_nvm_timing_clock_div #(
    .DW       (ecd_pkg::DIV_FIELD_W)
  ) u_div (
    .clk      (clk),
    .rstn     (rstn),
    .run      (loaded),
    .prescale (st_ff.clkdiv[ecd_pkg::DIV_PRESCALE_BIT]),
    .divisor  (st_ff.clkdiv[ecd_pkg::DIV_FIELD_W-1:0]),
    .tick     (tick)
  );

  function automatic logic [32:0] read_word(input logic [7:0] a,
                                            input ecd_top_state_s s);
    logic [32:0] r;
    logic        busy;
    r    = '0;
    busy = (s.op != ecd_pkg::OP_IDLE);
    if (a == ecd_pkg::OFS_CLKDIV) begin
      r[7:0] = s.clkdiv;
    end else if (a == ecd_pkg::OFS_OPTIONS) begin
      r[7:0] = s.options;
    end else if (a == ecd_pkg::OFS_CONFIG) begin
      r[7:0] = s.config_r;
    end else if (a == ecd_pkg::OFS_PROTECT) begin
      r[7:0] = s.protect;
    end else if (a == ecd_pkg::OFS_COMMAND) begin
      r[ecd_pkg::CMD_PROGRAM_BIT] = busy & ~s.erasing;
      r[ecd_pkg::CMD_ERASE_BIT]   = busy & s.erasing;
    end else if (a == ecd_pkg::OFS_STATUS) begin
      r[ecd_pkg::STAT_BUSY_BIT]    = busy;
      r[ecd_pkg::STAT_DONE_BIT]    = s.done;
      r[ecd_pkg::STAT_BLOCKED_BIT] = s.blocked;
    end else if (a == ecd_pkg::OFS_EEADDR) begin
      r[EE_AW-1:0] = s.eeaddr;
    end else begin
      r[32] = 1'b1;
    end
    return r;
  endfunction

  always_comb begin
    logic [32:0] rw;
    logic        clr_done;
    logic        clr_blk;
    logic        set_done;
    logic        set_blk;
    rw       = read_word(apb_req.paddr, st_ff);
    clr_done = 1'b0;
    clr_blk  = 1'b0;
    set_done = 1'b0;
    set_blk  = 1'b0;
    nxt_st   = st_ff;
    nxt_st.rd_addr = rd_phys;

    if (st_ff.loading) begin
      nxt_st.loading = 1'b0;
      nxt_st.options = nv_image.options;
      nxt_st.protect = nv_image.protect;
      nxt_st.key     = nv_image.key;
    end

    if (rd_cap) begin
      nxt_st.prdata  = rw[31:0];
      nxt_st.pslverr = rw[32];
    end

    if (wr_en) begin
      if (apb_req.paddr == ecd_pkg::OFS_CLKDIV) begin
        if (!loaded) begin
          nxt_st.clkdiv = {1'b1, wbyte[ecd_pkg::DIV_PRESCALE_BIT:0]};
        end
      end else if (apb_req.paddr == ecd_pkg::OFS_CONFIG) begin
        nxt_st.config_r = '0;
        nxt_st.config_r[ecd_pkg::CFG_PAGE_SEL_BIT] =
          wbyte[ecd_pkg::CFG_PAGE_SEL_BIT];
      end else if (apb_req.paddr == ecd_pkg::OFS_EEADDR) begin
        if (st_ff.op == ecd_pkg::OP_IDLE) begin
          nxt_st.eeaddr = apb_req.pwdata[EE_AW-1:0];
        end
      end else if (apb_req.paddr == ecd_pkg::OFS_STATUS) begin
        clr_done = wbyte[ecd_pkg::STAT_DONE_BIT];
        clr_blk  = wbyte[ecd_pkg::STAT_BLOCKED_BIT];
      end else if (apb_req.paddr == ecd_pkg::OFS_COMMAND) begin
        if (st_ff.op == ecd_pkg::OP_IDLE &&
            (wbyte[ecd_pkg::CMD_PROGRAM_BIT] ||
             wbyte[ecd_pkg::CMD_ERASE_BIT])) begin
          if (!loaded) begin
            set_blk = 1'b1;
          end else begin
            nxt_st.op      = ecd_pkg::OP_ALIGN;
            nxt_st.erasing = wbyte[ecd_pkg::CMD_ERASE_BIT];
            nxt_st.op_addr = cmd_phys;
            nxt_st.op_base = cmd_base;
          end
        end
      end
    end

    case (st_ff.op)
      ecd_pkg::OP_ALIGN: begin
        if (tick) begin
          nxt_st.op     = ecd_pkg::OP_RUN;
          nxt_st.pulses = st_ff.erasing ? ERASE_CNT : PROG_CNT;
        end
      end
      ecd_pkg::OP_RUN: begin
        if (tick) begin
          if (st_ff.pulses == PULSE_W'(1)) begin
            nxt_st.op = ecd_pkg::OP_IDLE;
            set_done  = 1'b1;
          end
          nxt_st.pulses = st_ff.pulses - 1'b1;
        end
      end
      default: begin
        nxt_st.pulses = '0;
      end
    endcase

    // Set beats clear so a finishing operation is never lost
    nxt_st.done    = set_done | (st_ff.done & ~clr_done);
    nxt_st.blocked = set_blk | (st_ff.blocked & ~clr_blk);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_ff          <= '0;
      st_ff.loading  <= 1'b1;
      st_ff.clkdiv   <= ecd_pkg::CLKDIV_RST;
      st_ff.config_r <= ecd_pkg::CONFIG_RST;
      st_ff.options  <= ecd_pkg::OPTIONS_RST;
      st_ff.protect  <= ecd_pkg::PROTECT_RST;
      st_ff.op       <= ecd_pkg::OP_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Zero-wait slave; read data was captured in the setup cycle
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = st_ff.pslverr;
  assign apb_rsp.prdata  = st_ff.prdata;

  // only mapped half reaches the array
  assign ee_phys_addr        = st_ff.rd_addr;
  assign op_program          = (st_ff.op == ecd_pkg::OP_RUN) & ~st_ff.erasing;
  assign op_erase            = (st_ff.op == ecd_pkg::OP_RUN) & st_ff.erasing;
  assign op_phys_addr        = st_ff.op_addr;
  assign op_erase_base       = st_ff.op_base;
  assign timing_pulse        = tick;
  assign divisor_loaded_flag = loaded;
  assign eeprom_page_select  = page_sel;
  assign eeprom_sector_mode  = sect_mode;
  assign comparison_key      = st_ff.key;

endmodule

/* design/ecd_pkg.sv */
// Constants, register map and carrier types for the nonvolatile memory
// controller slice: EEPROM paging and the write-once timing clock divider.
// Assumes a 32-bit APB master on the bus clock and a synchronous reset.
// Summary of operation
// - Only one half of EEPROM is visible
// - Sector mode bit picks 4- or 8-byte
// - 4-byte mode: page picks sector half
// - 4-byte erase clears whole eight bytes
// - 8-byte mode: sectors sit in one page
// - 8-byte erase clears foreground sector only
// - Seven registers; two loaded from nonvolatile
// - Eight-byte comparison key is held
// - Divider bit 7 read-only; rest write-once
// - Reset clears loaded flag; first write sets
// - No program or erase until loaded
// - Prescale bit selects bus or bus/8
// - Divide selected clock by divisor plus one
// - Each timing pulse is one timing cycle
// - Operations use whole numbers of pulses
// - Page select 0 shows page 0, 1 page 1
// - Sector mode is options bit 5, reset-loaded
package ecd_pkg;

  localparam int unsigned APB_AW = 8;
  localparam int unsigned APB_DW = 32;
  localparam int unsigned REG_W  = 8;

  // Register byte addresses
  localparam logic [7:0] OFS_CLKDIV  = 8'h00;
  localparam logic [7:0] OFS_OPTIONS = 8'h04;
  localparam logic [7:0] OFS_CONFIG  = 8'h08;
  localparam logic [7:0] OFS_PROTECT = 8'h0C;
  localparam logic [7:0] OFS_COMMAND = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  localparam logic [7:0] OFS_EEADDR  = 8'h18;

  // Divider register fields
  localparam int unsigned DIV_LOADED_BIT   = 7;
  localparam int unsigned DIV_PRESCALE_BIT = 6;
  localparam int unsigned DIV_FIELD_W      = 6;

  // Options, config, command and status fields
  localparam int unsigned OPT_SECTOR_MODE_BIT = 5;
  localparam int unsigned CFG_PAGE_SEL_BIT    = 6;
  localparam int unsigned CMD_PROGRAM_BIT     = 0;
  localparam int unsigned CMD_ERASE_BIT       = 1;
  localparam int unsigned STAT_BUSY_BIT       = 0;
  localparam int unsigned STAT_DONE_BIT       = 1;
  localparam int unsigned STAT_BLOCKED_BIT    = 2;

  // Reset values
  localparam logic [7:0] CLKDIV_RST  = 8'h00;
  localparam logic [7:0] CONFIG_RST  = 8'h00;
  localparam logic [7:0] OPTIONS_RST = 8'h00;
  localparam logic [7:0] PROTECT_RST = 8'h00;

  // Prescaler and sector geometry
  localparam int unsigned PRESCALE_W   = 3;
  localparam logic [2:0]  PRESCALE_TOP = 3'h7;
  localparam int unsigned SECTOR_AW    = 3;
  localparam int unsigned HALF_AW      = 2;
  localparam int unsigned KEY_W        = 64;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_ALIGN,
    OP_RUN
  } ecd_op_e;

  typedef struct packed {
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [APB_AW-1:0]   paddr;
    logic [APB_DW-1:0]   pwdata;
  } ecd_apb_req_s;

  typedef struct packed {
    logic                pready;
    logic                pslverr;
    logic [APB_DW-1:0]   prdata;
  } ecd_apb_rsp_s;

  typedef struct packed {
    logic [7:0]   options;
    logic [7:0]   protect;
    logic [63:0]  key;
  } ecd_nv_image_s;

endpackage

/* design/ecd_ee_map.sv */
// EEPROM logical-to-physical address mapping for the two sector modes.
// Assumes a physical array twice the size of the visible window.
`timescale 1ns/1ps
module ecd_ee_map #(
  parameter int unsigned AW = 10
) (
  // Logical foreground address
  input  wire logic [AW-1:0] addr,
  // Mapping controls
  input  wire logic          page_sel,
  input  wire logic          sector_mode,
  // Physical results
  output      logic [AW:0]   phys_addr,
  output      logic [AW:0]   erase_base
);

  generate
    if (AW < ecd_pkg::SECTOR_AW) begin : g_chk
      $error("ecd_ee_map: AW too small for 8-byte sectors");
    end
  endgenerate

  function automatic logic [AW:0] map_addr(input logic [AW-1:0] a,
                                           input logic          pg,
                                           input logic          md);
    logic [AW:0] r;
    r = '0;
    if (md) begin
      r = {pg, a};
    end else begin
      r = {a[AW-1:ecd_pkg::HALF_AW], pg, a[ecd_pkg::HALF_AW-1:0]};
    end
    return r;
  endfunction

  always_comb begin
    phys_addr  = map_addr(addr, page_sel, sector_mode);
    // full 8 bytes in 4-byte mode
    erase_base = {phys_addr[AW:ecd_pkg::SECTOR_AW],
                  {ecd_pkg::SECTOR_AW{1'b0}}};
  end

endmodule

/* design/ecd_nvm_timing_clock_div.sv */
// Nonvolatile timing clock divider: optional divide by 8, then by div+1.
// Emits a one-cycle strobe at the end of each timing clock period.
// Assumes settings stay constant while run is high.
`timescale 1ns/1ps
module ecd_nvm_timing_clock_div #(
  parameter int unsigned DW = ecd_pkg::DIV_FIELD_W
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // Settings
  input  wire logic          run,
  input  wire logic          prescale,
  input  wire logic [DW-1:0] divisor,
  // Timing strobe
  output      logic          tick
);

  generate
    if (DW < 1) begin : g_chk
      $error("ecd_nvm_timing_clock_div: DW must be at least 1");
    end
  endgenerate

  typedef struct packed {
    logic [ecd_pkg::PRESCALE_W-1:0] pre_cnt;
    logic [DW-1:0]                  div_cnt;
    logic                           tick;
  } ecd_div_state_s;

  ecd_div_state_s st_ff;
  ecd_div_state_s nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.tick = 1'b0;
    if (!run) begin
      nxt_st.pre_cnt = '0;
      nxt_st.div_cnt = '0;
    end else begin
      // bus clock or bus clock / 8
      nxt_st.pre_cnt = prescale ? st_ff.pre_cnt + 1'b1 : '0;
      if (!prescale || st_ff.pre_cnt == ecd_pkg::PRESCALE_TOP) begin
        if (st_ff.div_cnt == divisor) begin
          nxt_st.div_cnt = '0;
          nxt_st.tick    = 1'b1;
        end else begin
          nxt_st.div_cnt = st_ff.div_cnt + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;

endmodule

/* tb/ecd_nvm_props.sv */
// Checker for the nvm controller top: mapping, divider and operations.
// Assumes it is bound to ecd_nvm_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module ecd_nvm_props #(
  parameter int unsigned EE_AW = 10
) (
  // Clock and reset
  input wire logic                      clk,
  input wire logic                      rstn,
  // Register bus
  input wire ecd_pkg::ecd_apb_req_s     apb_req,
  input wire ecd_pkg::ecd_apb_rsp_s     apb_rsp,
  input wire ecd_pkg::ecd_nv_image_s    nv_image,
  // EEPROM and operation
  input wire logic [EE_AW-1:0]          ee_addr,
  input wire logic [EE_AW:0]            ee_phys_addr,
  input wire logic                      op_program,
  input wire logic                      op_erase,
  input wire logic [EE_AW:0]            op_phys_addr,
  input wire logic [EE_AW:0]            op_erase_base,
  input wire logic                      timing_pulse,
  // Loaded settings
  input wire logic                      divisor_loaded_flag,
  input wire logic                      eeprom_page_select,
  input wire logic                      eeprom_sector_mode,
  input wire logic [ecd_pkg::KEY_W-1:0] comparison_key
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic acc_w;
  assign acc_w = apb_req.psel && apb_req.penable && apb_req.pwrite;

  map_eight_a: assert property (
    $past(rstn, 2) && $past(eeprom_sector_mode) |->
    ee_phys_addr == {$past(eeprom_page_select), $past(ee_addr)})
    else $error("8-byte mode map wrong");
  map_four_a: assert property (
    $past(rstn, 2) && !$past(eeprom_sector_mode) |->
    ee_phys_addr == {$past(ee_addr[EE_AW-1:2]),
                     $past(eeprom_page_select), $past(ee_addr[1:0])})
    else $error("4-byte mode map wrong");
  erase_base_a: assert property (
    op_erase |-> op_erase_base == {op_phys_addr[EE_AW:3], 3'h0})
    else $error("erase base wrong");
  ops_blocked_a: assert property (
    !divisor_loaded_flag |-> !op_program && !op_erase)
    else $error("operation while divider unloaded");
  flag_hold_a: assert property (
    $past(rstn) && $past(divisor_loaded_flag) |-> divisor_loaded_flag)
    else $error("loaded flag dropped");
  flag_set_a: assert property (
    acc_w && apb_req.paddr == ecd_pkg::OFS_CLKDIV |=> divisor_loaded_flag)
    else $error("loaded flag not set by write");
  op_start_a: assert property (
    $rose(op_erase) || $rose(op_program) |-> $past(timing_pulse))
    else $error("operation not aligned to pulse");
  nv_copy_a: assert property (
    $past(rstn) && $past(rstn, 2) |-> comparison_key == nv_image.key &&
    eeprom_sector_mode == nv_image.options[ecd_pkg::OPT_SECTOR_MODE_BIT])
    else $error("reset copy wrong");
  unmapped_a: assert property (
    apb_req.psel && !apb_req.penable &&
    apb_req.paddr > ecd_pkg::OFS_EEADDR |=> apb_rsp.pslverr)
    else $error("unmapped access not flagged");

  cover property ($rose(op_erase));
  cover property ($rose(op_program));
  cover property (apb_rsp.pslverr);
endmodule

bind ecd_nvm_ctrl ecd_nvm_props #(.EE_AW(EE_AW)) u_props (
  .clk(clk), .rstn(rstn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .nv_image(nv_image), .ee_addr(ee_addr), .ee_phys_addr(ee_phys_addr),
  .op_program(op_program), .op_erase(op_erase), .op_phys_addr(op_phys_addr),
  .op_erase_base(op_erase_base), .timing_pulse(timing_pulse),
  .divisor_loaded_flag(divisor_loaded_flag),
  .eeprom_page_select(eeprom_page_select),
  .eeprom_sector_mode(eeprom_sector_mode),
  .comparison_key(comparison_key));

/* tb/tb.sv */
// Self-checking bench for the nvm controller slice, both sector modes.
// Assumes the default 10-bit EEPROM window and the bound checker.
`timescale 1ns/1ps
module tb;
  logic                   clk;
  logic                   rstn;
  ecd_pkg::ecd_apb_req_s  req;
  ecd_pkg::ecd_apb_rsp_s  rsp;
  ecd_pkg::ecd_nv_image_s nv;
  ecd_pkg::ecd_nv_image_s nvx;
  logic [9:0]             ee_addr;
  logic [10:0]            ee_phys;
  logic [10:0]            op_phys;
  logic [10:0]            op_base;
  logic                   op_prog;
  logic                   op_erase;
  logic                   pulse;
  logic                   loaded;
  logic                   page;
  logic                   mode;
  logic [63:0]            key;
  logic [31:0]            q;
  logic                   e;
  logic [6:0]             dv;
  logic [9:0]             a;
  int                     n_errors;
  int                     comparisons;
  int                     seed;
  int                     n;
  int                     per;

  // Short pulse counts keep each operation brief
  ecd_nvm_ctrl #(.PROG_PULSES(3), .ERASE_PULSES(2)) uut (
    .clk(clk), .rstn(rstn), .apb_req(req), .apb_rsp(rsp), .nv_image(nv),
    .ee_addr(ee_addr), .ee_phys_addr(ee_phys), .op_program(op_prog),
    .op_erase(op_erase), .op_phys_addr(op_phys), .op_erase_base(op_base),
    .timing_pulse(pulse), .divisor_loaded_flag(loaded),
    .eeprom_page_select(page), .eeprom_sector_mode(mode),
    .comparison_key(key));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic results();
    if (n_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] seen,
                     input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, ad, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 50);
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (rsp.pready !== 1'b1) begin
      n_errors++;
      results();
    end
  endtask

  // Watched output: 0 timing pulse, 1 program, 2 erase
  function automatic logic pick(input int sel);
    logic r;
    r = op_erase;
    if (sel == 0) r = pulse;
    else if (sel == 1) r = op_prog;
    return r;
  endfunction

  // Counts edges until the output reaches the wanted level
  task automatic wait_on(input int sel, input logic v, output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (pick(sel) !== v && k < 20000);
    if (pick(sel) !== v) begin
      n_errors++;
      results();
    end
  endtask

  function automatic logic [10:0] map(input logic [9:0] ad, input logic p,
                                      input logic md);
    return md ? {p, ad} : {ad[9:2], p, ad[1:0]};
  endfunction

  initial begin
    seed = 60;
    n_errors = 0;
    comparisons = 0;
    rstn = 1'b0;
    req = '0;
    nv = '0;
    ee_addr = '0;
    for (int m = 0; m < 2; m++) begin
      nvx.key = {$random(seed), $random(seed)};
      nvx.options = 8'($random(seed));
      nvx.protect = 8'($random(seed));
      nvx.options[5] = m[0];
      @(posedge clk);
      rstn <= 1'b0;
      nv <= nvx;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
      apb(1'b0, ecd_pkg::OFS_OPTIONS, 32'h0);
      chk("options", q, nvx.options);
      apb(1'b0, ecd_pkg::OFS_PROTECT, 32'h0);
      chk("protect", q, nvx.protect);
      chk("key", key, nvx.key);
      chk("mode", mode, m[0]);
      apb(1'b0, ecd_pkg::OFS_CLKDIV, 32'h0);
      chk("divider reset", q, 64'h0);
      chk("loaded reset", loaded, 64'h0);
      apb(1'b1, ecd_pkg::OFS_COMMAND, 32'h2);
      apb(1'b0, ecd_pkg::OFS_STATUS, 32'h0);
      chk("blocked", q, 64'h4);
      chk("no erase", op_erase, 64'h0);
      apb(1'b1, ecd_pkg::OFS_STATUS, 32'h4);
      apb(1'b0, 8'h1C, 32'h0);
      chk("unmapped", {e, q}, 64'h1_0000_0000);
      // whole range drawn: even the longest 512-cycle period keeps runs brief
      dv = 7'($random(seed));
      per = (dv[5:0] + 1) * (dv[6] ? 8 : 1);
      // Divider written only after the blocked erase command
      apb(1'b1, ecd_pkg::OFS_CLKDIV, {25'h0, dv});
      apb(1'b1, ecd_pkg::OFS_CLKDIV, {25'h0, ~dv});
      apb(1'b0, ecd_pkg::OFS_CLKDIV, 32'h0);
      chk("divider", q, {56'h0, 1'b1, dv});
      chk("loaded set", loaded, 64'h1);
      wait_on(0, 1'b1, n);
      wait_on(0, 1'b1, n);
      chk("period", 64'(n), 64'(per));
      for (int i = 0; i < 6; i++) begin
        a = 10'($random(seed));
        @(posedge clk);
        ee_addr <= a;
        apb(1'b1, ecd_pkg::OFS_CONFIG, {25'h0, i[0], 6'h0});
        repeat (2) @(posedge clk);
        #1;
        chk("page", page, i[0]);
        chk("map", ee_phys, map(a, i[0], m[0]));
        if (i > 3) begin
          apb(1'b1, ecd_pkg::OFS_EEADDR, {22'h0, a});
          apb(1'b1, ecd_pkg::OFS_COMMAND, i[0] ? 32'h1 : 32'h2);
          wait_on(i[0] ? 1 : 2, 1'b1, n);
          chk("op addr", op_phys, map(a, i[0], m[0]));
          if (!i[0])
            chk("base", op_base, map(a, 1'b0, m[0]) & 11'h7F8);
          wait_on(i[0] ? 1 : 2, 1'b0, n);
          chk("op length", 64'(n), 64'(per * (i[0] ? 3 : 2)));
          apb(1'b0, ecd_pkg::OFS_STATUS, 32'h0);
          chk("done", q, 64'h2);
          apb(1'b1, ecd_pkg::OFS_STATUS, 32'h2);
        end
      end
    end
    results();
  end
endmodule
